// ---- cscr_pkg.sv ----
// Constants and types for the carrier status and control register.
package cscr_pkg;
    localparam logic [7:0] CSR_OFFSET = 8'hC1;
    localparam int BIT_AUTO_CLEAR = 7;
    localparam int BIT_AUTO_ACK_DIS = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_IRQ_PENDING = 2;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RESET_NS = 1000;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
    localparam int ACCESS_TIMEOUT_CYCLES = 64;
    localparam int NUM_SLOTS = 4;
    typedef enum logic [2:0] {
        CSCR_IDLE = 3'b001,
        CSCR_WAIT = 3'b010,
        CSCR_DONE = 3'b100
    } cscr_acc_e;
endpackage : cscr_pkg

// ---- cscr_pulse_timer.sv ----
// Down counter that holds its busy output for a fixed number of cycles.
`timescale 1ns/1ns
module cscr_pulse_timer #(
    parameter int CYCLES = 100
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = 16'(CYCLES);
        end else if (cnt_reg != 16'h0000) begin
            cnt_next = cnt_reg - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign busy = (cnt_reg != 16'h0000);
endmodule : cscr_pulse_timer

// ---- cscr_carrier_status.sv ----
// Carrier status and control register with pending, acknowledge and reset logic.
`timescale 1ns/1ns
module cscr_carrier_status #(
    parameter int TIMEOUT_CYCLES = cscr_pkg::ACCESS_TIMEOUT_CYCLES,
    parameter int NSLOT = cscr_pkg::NUM_SLOTS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mod_access,
    input wire logic mod_ack,
    output logic carrier_ack,
    input wire logic [NSLOT-1:0] mod_irq_req,
    input wire logic [NSLOT-1:0] pend_clear,
    output logic [NSLOT-1:0] irq_pending,
    output logic irq_enable,
    output logic soft_reset
);
    logic [NSLOT-1:0] irq_s1_reg;
    logic [NSLOT-1:0] irq_s2_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic auto_clear_pending_enable_reg, auto_clear_pending_enable_next;
    logic auto_ack_disable_reg, auto_ack_disable_next;
    logic timeout_access_flag_reg, timeout_access_flag_next;
    logic global_irq_enable_reg, global_irq_enable_next;
    logic [NSLOT-1:0] pend_reg, pend_next;
    logic [7:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic srst_reg;
    logic srst_start;
    logic srst_busy;
    logic [15:0] tmo_reg, tmo_next;
    cscr_pkg::cscr_acc_e acc_reg, acc_next;
    logic hit_wr, hit_rd, tmo_event;

    function automatic logic [7:0] pack_status(input logic auto_clr, input logic ack_dis,
                                               input logic tmo_flag, input logic irq_en,
                                               input logic irq_pend);
        logic [7:0] v;
        v = cscr_pkg::CSR_RESET;
        v[cscr_pkg::BIT_AUTO_CLEAR] = auto_clr;
        v[cscr_pkg::BIT_AUTO_ACK_DIS] = ack_dis;
        v[cscr_pkg::BIT_TIMEOUT] = tmo_flag;
        v[cscr_pkg::BIT_IRQ_ENABLE] = irq_en;
        v[cscr_pkg::BIT_IRQ_PENDING] = irq_pend;
        return v;
    endfunction : pack_status

    always_ff @(posedge ref_clk) begin
        irq_s1_reg <= mod_irq_req;
        irq_s2_reg <= irq_s1_reg;
        ack_s1_reg <= mod_ack;
        ack_s2_reg <= ack_s1_reg;
    end

    assign hit_wr = reg_sel && reg_wr && (reg_addr == cscr_pkg::CSR_OFFSET);
    assign hit_rd = reg_sel && reg_rd && (reg_addr == cscr_pkg::CSR_OFFSET);
    assign srst_start = hit_wr && reg_wdata[cscr_pkg::BIT_SOFT_RESET];

    // Module access tracker: counts to the timeout unless the module answers.
    always_comb begin
        acc_next = acc_reg;
        tmo_next = tmo_reg;
        tmo_event = 1'b0;
        ack_next = 1'b0;
        unique case (acc_reg)
            cscr_pkg::CSCR_IDLE: begin
                if (mod_access) begin
                    acc_next = cscr_pkg::CSCR_WAIT;
                    tmo_next = 16'h0000;
                end
            end
            cscr_pkg::CSCR_WAIT: begin
                if (ack_s2_reg) begin
                    acc_next = cscr_pkg::CSCR_DONE;
                    ack_next = 1'b1;
                end else if (tmo_reg == 16'(TIMEOUT_CYCLES - 1)) begin
                    acc_next = cscr_pkg::CSCR_DONE;
                    tmo_event = 1'b1;
                    ack_next = !auto_ack_disable_reg;
                end else begin
                    tmo_next = tmo_reg + 16'h0001;
                end
            end
            cscr_pkg::CSCR_DONE: begin
                if (!mod_access) begin
                    acc_next = cscr_pkg::CSCR_IDLE;
                end else begin
                    ack_next = ack_reg;
                end
            end
            default: acc_next = cscr_pkg::CSCR_IDLE;
        endcase
    end

    always_comb begin
        auto_clear_pending_enable_next = auto_clear_pending_enable_reg;
        auto_ack_disable_next = auto_ack_disable_reg;
        global_irq_enable_next = global_irq_enable_reg;
        timeout_access_flag_next = timeout_access_flag_reg;
        if (hit_wr) begin
            auto_clear_pending_enable_next = reg_wdata[cscr_pkg::BIT_AUTO_CLEAR];
            auto_ack_disable_next = reg_wdata[cscr_pkg::BIT_AUTO_ACK_DIS];
            global_irq_enable_next = reg_wdata[cscr_pkg::BIT_IRQ_ENABLE];
        end
        if (hit_rd) begin
            timeout_access_flag_next = 1'b0;
        end
        // A timeout in the same cycle as a read wins, so the event is never lost.
        if (tmo_event) begin
            timeout_access_flag_next = 1'b1;
        end
        // A live request wins over a clear that arrives in the same cycle.
        if (auto_clear_pending_enable_reg) begin
            pend_next = irq_s2_reg;
        end else begin
            pend_next = (pend_reg & ~pend_clear) | irq_s2_reg;
        end
        rdata_next = rdata_reg;
        if (hit_rd) begin
            rdata_next = pack_status(auto_clear_pending_enable_reg, auto_ack_disable_reg,
                                     timeout_access_flag_reg, global_irq_enable_reg,
                                     |pend_reg);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            auto_clear_pending_enable_reg <= 1'b0;
            auto_ack_disable_reg <= 1'b0;
            timeout_access_flag_reg <= 1'b0;
            global_irq_enable_reg <= 1'b0;
            pend_reg <= '0;
            rdata_reg <= cscr_pkg::CSR_RESET;
            ack_reg <= 1'b0;
            srst_reg <= 1'b0;
            tmo_reg <= 16'h0000;
            acc_reg <= cscr_pkg::CSCR_IDLE;
        end else begin
            auto_clear_pending_enable_reg <= auto_clear_pending_enable_next;
            auto_ack_disable_reg <= auto_ack_disable_next;
            timeout_access_flag_reg <= timeout_access_flag_next;
            global_irq_enable_reg <= global_irq_enable_next;
            pend_reg <= pend_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            srst_reg <= srst_busy;
            tmo_reg <= tmo_next;
            acc_reg <= acc_next;
        end
    end

    cscr_pulse_timer #(
        .CYCLES(cscr_pkg::SOFT_RESET_CYCLES)
    ) u_srst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(srst_start),
        .busy(srst_busy)
    );

    assign reg_rdata = rdata_reg;
    assign carrier_ack = ack_reg;
    assign irq_pending = pend_reg;
    assign irq_enable = global_irq_enable_reg;
    assign soft_reset = srst_reg;

    // Counts how long the software reset has stood, for the pulse width checks.
    logic [15:0] srst_len_reg;
    logic [15:0] srst_len_next;

    always_comb begin
        srst_len_next = 16'h0000;
        if (soft_reset) begin
            srst_len_next = srst_len_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            srst_len_reg <= 16'h0000;
        end else begin
            srst_len_reg <= srst_len_next;
        end
    end

    chk_srst_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(soft_reset) |-> soft_reset [*8]) else $error("soft reset too short");
    chk_srst_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(soft_reset) |-> srst_len_reg == 16'(cscr_pkg::SOFT_RESET_CYCLES))
        else $error("soft reset width wrong");
    chk_srst_max: assert property (@(posedge ref_clk) disable iff (sys_rst)
        soft_reset |-> srst_len_reg < 16'(cscr_pkg::SOFT_RESET_CYCLES))
        else $error("soft reset too long");
    chk_srst_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
        srst_start |-> ##2 soft_reset) else $error("soft reset not started");
    chk_tmo_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit_rd && !tmo_event |=> !timeout_access_flag_reg) else $error("timeout not cleared");
    chk_tmo_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tmo_event |=> timeout_access_flag_reg) else $error("timeout not set");
    chk_ack_dis: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tmo_event && auto_ack_disable_reg |=> !carrier_ack) else $error("ack while disabled");
    chk_ack_auto: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tmo_event && !auto_ack_disable_reg |=> carrier_ack) else $error("missing auto ack");
    chk_rd_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rdata[1:0] == 2'h0) else $error("unused bits nonzero");
    chk_auto_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        auto_clear_pending_enable_reg |=> irq_pending == $past(irq_s2_reg)) else $error("pending latched");
    chk_gip_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit_rd |=> reg_rdata[cscr_pkg::BIT_IRQ_PENDING] == $past(|pend_reg)) else $error("bad pending bit");
    chk_gie_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit_wr |=> irq_enable == $past(reg_wdata[cscr_pkg::BIT_IRQ_ENABLE]))
        else $error("enable not written");
    chk_gie_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !hit_wr |=> $stable(irq_enable)) else $error("enable changed without write");
    chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit_wr |=> auto_ack_disable_reg == $past(reg_wdata[cscr_pkg::BIT_AUTO_ACK_DIS])
        && auto_clear_pending_enable_reg == $past(reg_wdata[cscr_pkg::BIT_AUTO_CLEAR]))
        else $error("control bits not written");
endmodule : cscr_carrier_status

// ---- cscr_slot_model.sv ----
// Module slot model that answers module accesses when a module is fitted.
`timescale 1ns/1ns
module cscr_slot_model (
    input wire logic ref_clk,
    input wire logic mod_access,
    input wire logic present,
    output logic mod_ack
);
    logic [1:0] dly_reg = 2'h0;
    // An empty slot never answers, so its acknowledge line rests inactive.
    always @(posedge ref_clk) begin
        dly_reg <= (mod_access && present) ? {dly_reg[0], 1'b1} : 2'h0;
        mod_ack <= dly_reg[1] && mod_access && present;
    end
endmodule : cscr_slot_model

// ---- tb_top.sv ----
// Testbench for the carrier status and control register.
`timescale 1ns/1ns
module tb_top;
    localparam int TO = 8;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
    logic mod_access = 1'b0, mod_ack, carrier_ack, irq_enable, soft_reset, present = 1'b0;
    logic [3:0] mod_irq_req = 4'h0, pend_clear = 4'h0, irq_pending;
    int fail_count = 0, comparisons = 0, cycles = 0, n;
    always #5 ref_clk = ~ref_clk;
    cscr_carrier_status #(.TIMEOUT_CYCLES(TO), .NSLOT(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mod_access(mod_access), .mod_ack(mod_ack), .carrier_ack(carrier_ack),
        .mod_irq_req(mod_irq_req), .pend_clear(pend_clear), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .soft_reset(soft_reset));
    cscr_slot_model slot (.ref_clk(ref_clk), .mod_access(mod_access), .present(present), .mod_ack(mod_ack));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_sel = 1'b1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cyc(1);
        rd_val = reg_rdata;
    endtask : acc
    task automatic mod_cycle(input logic fitted, input logic exp_ack);
        present = fitted;
        mod_access = 1'b1;
        for (n = 0; n < TO + 20 && carrier_ack !== 1'b1; n++) cyc(1);
        chk({7'h0, carrier_ack}, {7'h0, exp_ack});
        mod_access = 1'b0;
        cyc(4);
    endtask : mod_cycle
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        cyc(4);
        sys_rst = 1'b0;
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        chk({7'h0, irq_enable}, 8'h00);
        acc(1'b1, 8'hC1, 8'hEB);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'hC8);
        chk({7'h0, irq_enable}, 8'h01);
        acc(1'b1, 8'hC3, 8'h00);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'hC8);
        $display("test registers done");
        acc(1'b1, 8'hC1, 8'h00);
        mod_cycle(1'b0, 1'b1);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h20);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        mod_cycle(1'b1, 1'b1);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        acc(1'b1, 8'hC1, 8'h40);
        mod_cycle(1'b0, 1'b0);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h60);
        mod_cycle(1'b1, 1'b1);
        $display("test acknowledge done");
        acc(1'b1, 8'hC1, 8'h00);
        mod_irq_req = 4'h1;
        cyc(6);
        chk({4'h0, irq_pending}, 8'h01);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h04);
        mod_irq_req = 4'h0;
        cyc(6);
        chk({4'h0, irq_pending}, 8'h01);
        pend_clear = 4'h1;
        cyc(1);
        pend_clear = 4'h0;
        cyc(3);
        chk({4'h0, irq_pending}, 8'h00);
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        acc(1'b1, 8'hC1, 8'h80);
        mod_irq_req = 4'h8;
        cyc(6);
        chk({4'h0, irq_pending}, 8'h08);
        mod_irq_req = 4'h0;
        cyc(6);
        chk({4'h0, irq_pending}, 8'h00);
        $display("test pending done");
        for (n = 0; n < 10; n++) begin
            cyc(1);
            chk({7'h0, soft_reset}, 8'h00);
        end
        acc(1'b1, 8'hC1, 8'h10);
        for (n = 0; n < 5 && soft_reset !== 1'b1; n++) cyc(1);
        for (n = 0; n < 200 && soft_reset === 1'b1; n++) cyc(1);
        chk(n[7:0], 8'(cscr_pkg::SOFT_RESET_CYCLES));
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        $display("test software reset done");
        acc(1'b1, 8'hC1, 8'hC8);
        mod_cycle(1'b0, 1'b0);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        acc(1'b0, 8'hC1, 8'h00);
        chk(rd_val, 8'h00);
        chk({7'h0, irq_enable}, 8'h00);
        chk({7'h0, soft_reset}, 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb_top
